/* File: src/sbcl_bank.v */
// one bank state machine with its interval timer
`timescale 1ns/10ps
`include "sbcl_defines.vh"
module sbcl_bank #(
    parameter TW = 8
) (
    input  wire          clk_in,
    input  wire          reset_n_in,
    input  wire          ce_in,
    input  wire          sel_in,
    input  wire          all_in,
    input  wire [2:0]    cmd_in,
    input  wire          ap_in,
    input  wire [TW-1:0] twr_in,
    input  wire [TW-1:0] trp_in,
    input  wire [TW-1:0] trcd_in,
    input  wire [TW-1:0] trc_in,
    input  wire [TW-1:0] tmrd_in,
    output reg  [3:0]    state_q,
    output reg           illegal_out
);
    reg [TW-1:0] tmr_q;
    reg [TW-1:0] tmr_d;
    reg [3:0]    state_d;
    wire         hit = sel_in | all_in;
    wire         idle_cmd = (cmd_in == `SBCL_CMD_DESELECT) | (cmd_in == `SBCL_CMD_NOP);
    wire         done = (tmr_q <= {{(TW-1){1'b0}}, 1'b1});
    always @* begin
        state_d = state_q;
        tmr_d = done ? tmr_q : tmr_q - {{(TW-1){1'b0}}, 1'b1};
        illegal_out = 1'b0;
        case (state_q)
            `SBCL_ST_IDLE: begin
                if (all_in && cmd_in == `SBCL_CMD_REF) begin
                    state_d = `SBCL_ST_REFRESH;
                    tmr_d = trc_in;
                end else if (all_in && cmd_in == `SBCL_CMD_MRS) begin
                    state_d = `SBCL_ST_MODEREG;
                    tmr_d = tmrd_in;
                end else if (sel_in && cmd_in == `SBCL_CMD_ACT) begin
                    state_d = `SBCL_ST_ACTIVATE;
                    tmr_d = trcd_in;
                end else if (hit && (cmd_in == `SBCL_CMD_READ || cmd_in == `SBCL_CMD_WRITE)) begin
                    illegal_out = 1'b1;
                end
            end
            `SBCL_ST_ACTIVATE: begin
                // a refused command must not stretch the interval
                if (hit && !idle_cmd)
                    illegal_out = 1'b1;
                if (done)
                    state_d = `SBCL_ST_ACTIVE;
            end
            `SBCL_ST_ACTIVE: begin
                if (sel_in && cmd_in == `SBCL_CMD_WRITE) begin
                    state_d = ap_in ? `SBCL_ST_WRREC_AP : `SBCL_ST_WRREC;
                    tmr_d = twr_in;
                end else if (sel_in && cmd_in == `SBCL_CMD_READ && ap_in) begin
                    state_d = `SBCL_ST_PRECHARGE;
                    tmr_d = trp_in;
                end else if (hit && cmd_in == `SBCL_CMD_PRE) begin
                    state_d = `SBCL_ST_PRECHARGE;
                    tmr_d = trp_in;
                end else if (hit && (cmd_in == `SBCL_CMD_ACT || cmd_in[2:1] == 2'b11)) begin
                    illegal_out = 1'b1;
                end
            end
            `SBCL_ST_WRREC: begin
                if (sel_in && cmd_in == `SBCL_CMD_WRITE) begin
                    state_d = ap_in ? `SBCL_ST_WRREC_AP : `SBCL_ST_WRREC;
                    tmr_d = twr_in;
                end else begin
                    if (hit && !idle_cmd)
                        illegal_out = 1'b1;
                    if (done)
                        state_d = `SBCL_ST_ACTIVE;
                end
            end
            `SBCL_ST_WRREC_AP: begin
                if (hit && !idle_cmd)
                    illegal_out = 1'b1;
                if (done) begin
                    state_d = `SBCL_ST_PRECHARGE;
                    tmr_d = trp_in;
                end
            end
            `SBCL_ST_PRECHARGE: begin
                if (hit && !idle_cmd && cmd_in != `SBCL_CMD_PRE)
                    illegal_out = 1'b1;
                if (done)
                    state_d = `SBCL_ST_IDLE;
            end
            `SBCL_ST_REFRESH: begin
                if (hit && !idle_cmd)
                    illegal_out = 1'b1;
                if (done)
                    state_d = `SBCL_ST_IDLE;
            end
            `SBCL_ST_MODEREG: begin
                if (hit && !idle_cmd)
                    illegal_out = 1'b1;
                if (done)
                    state_d = `SBCL_ST_IDLE;
            end
            default: begin
                state_d = `SBCL_ST_IDLE;
            end
        endcase
        // illegal commands leave state and timer running as before
    end
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= `SBCL_ST_IDLE;
            tmr_q <= {TW{1'b0}};
        end else if (ce_in) begin
            state_q <= state_d;
            tmr_q <= tmr_d;
        end
    end
endmodule

/* File: include/sbcl_defines.vh */
// timing counts and encodings for the bank command legality block
`ifndef SBCL_DEFINES_VH
`define SBCL_DEFINES_VH
// bank states
`define SBCL_ST_IDLE      4'h0
`define SBCL_ST_ACTIVATE  4'h1
`define SBCL_ST_ACTIVE    4'h2
`define SBCL_ST_WRREC     4'h3
`define SBCL_ST_WRREC_AP  4'h4
`define SBCL_ST_PRECHARGE 4'h5
`define SBCL_ST_REFRESH   4'h6
`define SBCL_ST_MODEREG   4'h7
// decoded commands
`define SBCL_CMD_DESELECT 3'h0
`define SBCL_CMD_NOP      3'h1
`define SBCL_CMD_READ     3'h2
`define SBCL_CMD_WRITE    3'h3
`define SBCL_CMD_ACT      3'h4
`define SBCL_CMD_PRE      3'h5
`define SBCL_CMD_REF      3'h6
`define SBCL_CMD_MRS      3'h7
// times in ns except tMRD in cycles, cycle period in ns
`define SBCL_CLK_PERIOD_NS 50
`define SBCL_TWR_NS        15
`define SBCL_TRP_NS        15
`define SBCL_TRCD_NS       15
`define SBCL_TRC_NS        60
`define SBCL_TMRD_CYC      2
// least times round up to whole cycles
`define SBCL_CYC(ns) (((ns) + `SBCL_CLK_PERIOD_NS - 1) / `SBCL_CLK_PERIOD_NS)
`define SBCL_TWR_CYC  `SBCL_CYC(`SBCL_TWR_NS)
`define SBCL_TRP_CYC  `SBCL_CYC(`SBCL_TRP_NS)
`define SBCL_TRCD_CYC `SBCL_CYC(`SBCL_TRCD_NS)
`define SBCL_TRC_CYC  `SBCL_CYC(`SBCL_TRC_NS)
`endif

/* File: src/sbcl_top.v */
// command decoder and per-bank legality tracking
`timescale 1ns/10ps
`include "sbcl_defines.vh"
// Summary of operation
// - write recovery returns to active after tWR
// - auto-precharge recovery goes precharging after tWR
// - refresh returns idle after tRC
// - mode register access idle after tMRD
// - decode cs ras cas we at edge
// - precharge becomes idle after tRP
// - activating reaches row active after tRCD
module sbcl_top #(
    parameter NB   = 4,
    parameter BW   = 2,
    parameter TW   = 8,
    parameter AP_BIT = 10
) (
    input  wire           CLK_IN,
    input  wire           RESET_N_IN,
    input  wire           CE_IN,
    input  wire           CS_N_IN,
    input  wire           RAS_N_IN,
    input  wire           CAS_N_IN,
    input  wire           WE_N_IN,
    input  wire [BW-1:0]  BA_IN,
    input  wire [13:0]    ADDR_IN,
    output reg  [2:0]     CMD_OUT,
    output reg            ILLEGAL_OUT,
    output reg  [NB-1:0]  BANK_IDLE_OUT,
    output reg  [NB*4-1:0] BANK_STATE_OUT
);
    localparam [TW-1:0] TWR  = `SBCL_TWR_CYC;
    localparam [TW-1:0] TRP  = `SBCL_TRP_CYC;
    localparam [TW-1:0] TRCD = `SBCL_TRCD_CYC;
    localparam [TW-1:0] TRC  = `SBCL_TRC_CYC;
    localparam [TW-1:0] TMRD = `SBCL_TMRD_CYC;

    // high chip select is deselect whatever the other lines show
    function [2:0] decode;
        input cs_n;
        input ras_n;
        input cas_n;
        input we_n;
        begin
            decode = `SBCL_CMD_DESELECT;
            if (!cs_n) begin
                case ({ras_n, cas_n, we_n})
                    3'b111: decode = `SBCL_CMD_NOP;
                    3'b101: decode = `SBCL_CMD_READ;
                    3'b100: decode = `SBCL_CMD_WRITE;
                    3'b011: decode = `SBCL_CMD_ACT;
                    3'b010: decode = `SBCL_CMD_PRE;
                    3'b001: decode = `SBCL_CMD_REF;
                    3'b000: decode = `SBCL_CMD_MRS;
                    default: decode = `SBCL_CMD_NOP;
                endcase
            end
        end
    endfunction

    wire [2:0]    cmd = decode(CS_N_IN, RAS_N_IN, CAS_N_IN, WE_N_IN);
    wire          ap  = ADDR_IN[AP_BIT];
    wire          glob = (cmd == `SBCL_CMD_REF) | (cmd == `SBCL_CMD_MRS) |
                         ((cmd == `SBCL_CMD_PRE) & ap);
    wire [NB-1:0] bill;
    wire          all_req_bad;
    // a refused all-bank command must not move the idle banks either
    wire [2:0]    bank_cmd = all_req_bad ? `SBCL_CMD_NOP : cmd;
    wire [NB*4-1:0] bst;
    genvar i;
    generate
        for (i = 0; i < NB; i = i + 1) begin : g_bank
            localparam [BW-1:0] BANK_ID = i;
            // each bank judges only commands aimed at it
            sbcl_bank #(.TW(TW)) u_bank (
                .clk_in      (CLK_IN),
                .reset_n_in  (RESET_N_IN),
                .ce_in       (CE_IN),
                .sel_in      (BA_IN == BANK_ID),
                .all_in      (glob),
                .cmd_in      (bank_cmd),
                .ap_in       (ap),
                .twr_in      (TWR),
                .trp_in      (TRP),
                .trcd_in     (TRCD),
                .trc_in      (TRC),
                .tmrd_in     (TMRD),
                .state_q     (bst[i*4 +: 4]),
                .illegal_out (bill[i])
            );
        end
    endgenerate

    integer k;
    reg [NB-1:0] idle_v;
    always @* begin
        for (k = 0; k < NB; k = k + 1)
            idle_v[k] = (bst[k*4 +: 4] == `SBCL_ST_IDLE);
    end
    // refresh or mode set with any bank busy is flagged
    assign all_req_bad = ((cmd == `SBCL_CMD_REF) | (cmd == `SBCL_CMD_MRS)) & ~(&idle_v);

    always @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            CMD_OUT <= `SBCL_CMD_DESELECT;
            ILLEGAL_OUT <= 1'b0;
            BANK_IDLE_OUT <= {NB{1'b1}};
            BANK_STATE_OUT <= {(NB*4){1'b0}};
        end else if (CE_IN) begin
            CMD_OUT <= cmd;
            ILLEGAL_OUT <= (|bill) | all_req_bad;
            BANK_IDLE_OUT <= idle_v;
            BANK_STATE_OUT <= bst;
        end
    end
endmodule

/* File: bench/sbcl_ctl_model.sv */
// command pin driver standing in for the memory controller
`timescale 1ns/10ps
module sbcl_ctl_model (
    input  wire logic [2:0]  cmd_in,
    input  wire logic        ap_in,
    input  wire logic [13:0] rnd_in,
    output logic             cs_n_out,
    output logic [2:0]       rcw_n_out,
    output logic [13:0]      addr_out
);
    // row, column and opcode bits are noise so no decode leans on them
    assign addr_out = {rnd_in[13:11], ap_in, rnd_in[9:0]};
    assign cs_n_out = cmd_in == 3'h0;
    // unselected lines wander rather than holding the last level
    assign rcw_n_out = cs_n_out ? rnd_in[2:0] : cmd_in == 3'h1 ? 3'h7 : 3'h7 - cmd_in;
endmodule

/* File: bench/sbcl_top_chk.sv */
// port assertions for the bank legality block
`timescale 1ns/10ps
module sbcl_top_chk #(
    parameter NB = 4
) (
    input wire logic             CLK_IN,
    input wire logic             RESET_N_IN,
    input wire logic             CE_IN,
    input wire logic             CS_N_IN,
    input wire logic             RAS_N_IN,
    input wire logic             CAS_N_IN,
    input wire logic             WE_N_IN,
    input wire logic [2:0]       CMD_OUT,
    input wire logic             ILLEGAL_OUT,
    input wire logic [NB-1:0]    BANK_IDLE_OUT,
    input wire logic [NB*4-1:0]  BANK_STATE_OUT
);
    wire [3:0] s0 = BANK_STATE_OUT[3:0];
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RESET_N_IN || !CE_IN);
    // delays assume one cycle of write recovery, precharge, activate; two of refresh, mode set
    a_desel_decode: assert property (CS_N_IN |=> CMD_OUT == 3'h0)
        else $error("deselect miscoded");
    a_nop_decode: assert property (!CS_N_IN && RAS_N_IN && CAS_N_IN && WE_N_IN |=> CMD_OUT == 3'h1)
        else $error("nop miscoded");
    a_illegal_cause: assert property (ILLEGAL_OUT |-> CMD_OUT > 3'h1)
        else $error("nop flagged illegal");
    a_wrrec_exit: assert property (s0 == 4'h3 |=> s0 inside {4'h2, 4'h3, 4'h4})
        else $error("bad exit from recovery");
    a_wrap_to_pre: assert property (s0 == 4'h4 |=> s0 == 4'h5)
        else $error("autoprecharge recovery stuck");
    a_refresh_len: assert property (s0 == 4'h6 && $past(s0) != 4'h6 |=> s0 == 4'h6 ##1 s0 == 4'h0)
        else $error("refresh length wrong");
    a_modereg_len: assert property (s0 == 4'h7 && $past(s0) != 4'h7 |=> s0 == 4'h7 ##1 s0 == 4'h0)
        else $error("mode set length wrong");
    a_act_done: assert property (s0 == 4'h1 |=> s0 == 4'h2)
        else $error("activate length wrong");
    a_pre_done: assert property (s0 == 4'h5 |=> s0 == 4'h0)
        else $error("precharge length wrong");
    a_refresh_all: assert property (s0 == 4'h6 |-> BANK_IDLE_OUT == {NB{1'b0}})
        else $error("refresh not on all banks");
endmodule

/* File: bench/sbcl_top_tb.sv */
// bench: directed then random commands against a reference model
`timescale 1ns/10ps
`include "sbcl_defines.vh"
module sbcl_top_tb;
    localparam [63:0] LEGAL = 64'h03032303_0B2F03D3;
    localparam [167:0] DIR = 168'h40_10_30_31_40_42_10_00_32_22_60_52_10_60_70_10_70_44_10_26_10;
    localparam integer TWR = `SBCL_TWR_CYC;
    localparam integer TRP = `SBCL_TRP_CYC;
    localparam integer TRCD = `SBCL_TRCD_CYC;
    localparam integer TRC = `SBCL_TRC_CYC;
    localparam integer TMRD = `SBCL_TMRD_CYC;
    reg         clk_in = 1'b0;
    reg         rst_n = 1'b0;
    reg  [2:0]  cmd_q = 3'h0;
    reg  [1:0]  ba_q = 2'h0;
    reg         ap_q = 1'b0;
    reg  [13:0] rnd_q = 14'h0000;
    reg  [7:0]  e;
    wire        cs_n;
    wire [2:0]  rcw_n;
    wire [13:0] addr;
    wire [2:0]  cmd_o;
    wire        ill_o;
    wire [3:0]  idle_o;
    wire [15:0] st_o;
    integer     errors = 0;
    integer     num_checks = 0;
    integer     seed = 32'h2E7D;
    integer     pc = 0, pb = 0, pa = 0, i, c, b;
    integer     st [0:3];
    integer     tm [0:3];
    always #25 clk_in = ~clk_in;
    sbcl_ctl_model u_ctl (.cmd_in(cmd_q), .ap_in(ap_q), .rnd_in(rnd_q), .cs_n_out(cs_n),
        .rcw_n_out(rcw_n), .addr_out(addr));
    sbcl_top u_dut (.CLK_IN(clk_in), .RESET_N_IN(rst_n), .CE_IN(1'b1), .CS_N_IN(cs_n),
        .RAS_N_IN(rcw_n[2]), .CAS_N_IN(rcw_n[1]), .WE_N_IN(rcw_n[0]), .BA_IN(ba_q),
        .ADDR_IN(addr), .CMD_OUT(cmd_o), .ILLEGAL_OUT(ill_o), .BANK_IDLE_OUT(idle_o),
        .BANK_STATE_OUT(st_o));
    task check(input [15:0] got, input [15:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // drives a command; results of the previous one are judged at the same edge
    task issue(input integer cn, input integer bn, input integer an);
        integer k, ok, nx;
        reg [15:0] es;
        reg [3:0]  ei;
        begin
            @(posedge clk_in);
            cmd_q <= cn[2:0];
            ba_q <= bn[1:0];
            ap_q <= an[0];
            rnd_q <= $random(seed);
            #1;
            ok = pc < 6 || st[0] + st[1] + st[2] + st[3] == 0;
            for (k = 0; k < 4; k = k + 1) begin
                es[k*4 +: 4] = st[k][3:0];
                ei[k] = st[k] == 0;
                if (pc >= 6 || k == pb)
                    ok = ok & LEGAL[st[k]*8+pc];
            end
            check({13'h0, cmd_o}, pc[15:0]);
            check({15'h0, ill_o}, {15'h0, ok == 0});
            check(st_o, es);
            check({12'h0, idle_o}, {12'h0, ei});
            for (k = 0; k < 4; k = k + 1) begin
                if (ok && (pc >= 6 || k == pb && pc >= 2)) begin
                    nx = pc == 2 ? (pa ? 5 : 2) : pc == 3 ? (pa ? 4 : 3) : pc == 4 ? 1 : pc;
                    tm[k] = nx == 1 ? TRCD : nx == 2 ? 0 : nx == 5 ? TRP : nx == 6 ? TRC
                        : nx == 7 ? TMRD : TWR;
                    st[k] = nx;
                end else if (tm[k] > 1) begin
                    tm[k] = tm[k] - 1;
                end else if (tm[k] == 1) begin
                    nx = st[k] == 4 ? 5 : st[k] == 1 || st[k] == 3 ? 2 : 0;
                    tm[k] = st[k] == 4 ? TRP : 0;
                    st[k] = nx;
                end
            end
            pc = cn;
            pb = bn;
            pa = an;
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d errors %0d", num_checks, errors);
            if (errors == 0 && num_checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    initial begin
        for (i = 0; i < 4; i = i + 1) begin
            st[i] = 0;
            tm[i] = 0;
        end
        repeat (2) @(posedge clk_in);
        rst_n <= 1'b1;
        for (i = 20; i >= 0; i = i - 1) begin
            e = DIR[i*8 +: 8];
            issue(e[7:4], e[2:1], e[0]);
        end
        // bursts, refresh pacing and hot-range entry stay out of the stimulus
        // no burst is ever cut short, no hot-range self refresh
        // precharge only to an active bank, where its outcome is unambiguous
        for (i = 0; i < 600; i = i + 1) begin
            c = $random(seed) & 7;
            b = $random(seed) & 3;
            if (c == 5 && !(st[b] == 2 && (pb != b || pc < 2)))
                c = 1;
            issue(c, b, c == 5 ? 0 : $random(seed) & 1);
        end
        issue(1, 0, 0);
        complete_run;
    end
endmodule
bind sbcl_top sbcl_top_chk #(.NB(NB)) u_chk (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN),
    .CE_IN(CE_IN), .CS_N_IN(CS_N_IN), .RAS_N_IN(RAS_N_IN), .CAS_N_IN(CAS_N_IN),
    .WE_N_IN(WE_N_IN), .CMD_OUT(CMD_OUT), .ILLEGAL_OUT(ILLEGAL_OUT),
    .BANK_IDLE_OUT(BANK_IDLE_OUT), .BANK_STATE_OUT(BANK_STATE_OUT));
